// *** include/hub_strap_cfg.svh ***
// Purpose: constants of the reset sequencer and strap block
// Assumes: pclk at 100 MHz
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef HUB_STRAP_CFG_SVH
`define HUB_STRAP_CFG_SVH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define HSC_CLK_MHZ          100
`define HSC_RESET_DELAY_US   40
`define HSC_RESET_DELAY_CYC  (`HSC_RESET_DELAY_US * `HSC_CLK_MHZ)
`define HSC_PIN_TURN_MS      50
`define HSC_PIN_TURN_CYC     (`HSC_PIN_TURN_MS * 1000 * `HSC_CLK_MHZ)
`define HSC_COUNT_W          23

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define HSC_REG_CTRL         8'h00
`define HSC_REG_LED          8'h04
`define HSC_REG_STATUS       8'h08

// ---------------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------------
`define HSC_CTRL_PWR_LSB     0
`define HSC_CTRL_CNT_LSB     4
`define HSC_CTRL_NREM_LSB    6

// ---------------------------------------------------------------------
// status fields
// ---------------------------------------------------------------------
`define HSC_ST_RUNNING       0
`define HSC_ST_GANG          1
`define HSC_ST_POL_HIGH      2
`define HSC_ST_SELF          3
`define HSC_ST_PIN_OUT       4
`define HSC_ST_OC_LSB        5
`define HSC_ST_SUSPEND       9

// ---------------------------------------------------------------------
// reset values and encodings
// ---------------------------------------------------------------------
`define HSC_LED_SEL_RESET    8'h00
`define HSC_CNT_FOUR         2'h0
`define HSC_CNT_THREE        2'h1
`define HSC_CNT_TWO          2'h2

`endif

// *** include/hub_strap_pkg.sv ***
// Purpose: types shared by the reset sequencer and the indicator driver
// Assumes: nothing beyond the constants header
// Notes:   all-zero is the reset value of every state struct
package hub_strap_pkg;

   typedef enum logic [2:0] {SEQ_HOLD, SEQ_DELAY, SEQ_SAMPLE, SEQ_WAIT, SEQ_RUN} seq_state_t;

   // port indicator selector per port, as a hub port feature sets it
   typedef enum logic [1:0] {LED_AUTO, LED_AMBER, LED_GREEN, LED_OFF} led_sel_t;

   typedef struct packed {
      logic       ext_n;
      logic       pg;
      logic       gang;
      logic       amber;
      logic       self_pwr;
      logic [3:0] oc_n;
      logic [1:0] cnt;
      logic [3:0] nrem;
   } pins_t;

   typedef struct packed {
      pins_t                   sync1;
      pins_t                   sync2;
      seq_state_t              seq;
      logic [22:0]             count;
      logic                    hub_rst_n;
      logic                    gang;
      logic                    pol_high;
      logic                    self_pwr;
      logic [3:0]              pwr_req;
      logic [1:0]              port_cnt;
      logic [3:0]              nrem;
      logic [7:0]              led_sel;
      logic [3:0]              pwr_lvl;
      logic                    pwr_oe;
      logic                    pin_out;
      logic                    susp_flag;
      logic [31:0]             prdata;
   } core_state_t;

   typedef struct packed {
      logic [3:0] green;
      logic [1:0] amber;
   } led_state_t;

endpackage

// *** include/port_led_if.sv ***
// Purpose: link between the strap core and the port indicator driver
// Assumes: both ends on pclk
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface port_led_if;
   logic       suspend;
   logic [3:0] port_on;
   logic [3:0] overcurrent;
   logic [7:0] sel;
   logic [3:0] green;
   logic [1:0] amber;

   modport core (output suspend, output port_on, output overcurrent, output sel,
                 input green, input amber);
   modport drv  (input suspend, input port_on, input overcurrent, input sel,
                 output green, output amber);
endinterface
`default_nettype wire

// *** core/port_led_drv.sv ***
// Purpose: port indicator driver, manual and automatic selection
// Assumes: inputs from logic on pclk
// Notes:   only two amber lamps exist, ports 3 and 4 have green only
`timescale 1ns/1ps
`default_nettype none
module port_led_drv
   import hub_strap_pkg::*;
(
   // clock and reset
   input  wire logic   pclk,
   input  wire logic   presetn,
   // core side
   port_led_if.drv     led
);

   led_state_t s;
   led_state_t next_s;

   // ---------------------------------------------------------------------
   // per-port colour: returns {green, amber}
   // ---------------------------------------------------------------------
   function automatic logic [1:0] colour(input logic [1:0] sel, input logic on,
                                         input logic oc);
      logic [1:0] c;
      c = 2'h0;
      case (led_sel_t'(sel))
         LED_AUTO:  c = oc ? 2'h1 : (on ? 2'h2 : 2'h0);
         LED_AMBER: c = 2'h1;
         LED_GREEN: c = 2'h2;
         LED_OFF:   c = 2'h0;
         default:   c = 2'h0;
      endcase
      return c;
   endfunction

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   always_comb begin
      logic [1:0] c;
      c = 2'h0;
      next_s = s;
      for (int i = 0; i < 4; i++) begin
         c = colour(led.sel[2*i +: 2], led.port_on[i], led.overcurrent[i]);
         next_s.green[i] = c[1] & ~led.suspend;
         if (i < 2) begin
            next_s.amber[i] = c[0] & ~led.suspend;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign led.green = s.green;
   assign led.amber = s.amber;

endmodule
`default_nettype wire

// *** core/hub_strap_reset_config.sv ***
// Purpose: power-on reset sequencing, strap capture and port power control
// Assumes: pins arrive asynchronously; hub logic signals are on pclk
// Notes:   registers over APB, zero wait states
//
// Added by the designer: the APB interface to the registers and the register addresses.
`include "hub_strap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module hub_strap_reset_config
   import hub_strap_pkg::*;
#(
   parameter int unsigned PIN_TURN_CYCLES = `HSC_PIN_TURN_CYC
)(
   // clock and bus reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // reset sources
   input  wire logic        ext_reset_n,
   input  wire logic        core_power_good,
   // shared gang strap / suspend pin
   input  wire logic        gang_strap_suspend_pin_in,
   output logic             gang_strap_suspend_pin_out,
   output logic             gang_strap_suspend_pin_oe,
   // other straps
   input  wire logic        self_power_strap,
   input  wire logic [1:0]  port_count_strap,
   input  wire logic [3:0]  non_removable_strap,
   // port power switches
   output logic [3:0]       port_power_switch_on,
   output logic [3:0]       port_power_switch_on_oe,
   input  wire logic [3:0]  port_overcurrent_n,
   // indicators
   output logic [3:0]       led_green,
   output logic [1:0]       led_amber_out,
   output logic [1:0]       led_amber_oe,
   input  wire logic        switch_polarity_strap_led,
   // hub logic side
   input  wire logic        global_suspend,
   input  wire logic [3:0]  port_enabled,
   output logic             hub_reset_n,
   output logic             gang_mode,
   output logic             self_powered,
   output logic [3:0]       active_ports,
   output logic [3:0]       non_removable,
   output logic [3:0]       port_overcurrent
);

   localparam logic [22:0] DELAY_LAST = 23'(`HSC_RESET_DELAY_CYC - 1);
   localparam logic [22:0] TURN_LAST  = 23'(PIN_TURN_CYCLES - 1);

   core_state_t s;
   core_state_t next_s;
   pins_t       pins_now;
   logic        rst_src;
   logic [3:0]  mask;
   logic [3:0]  oc_eff;
   logic [3:0]  on_req;
   logic        wr;
   logic        rd_setup;
   port_led_if  led_link ();

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------
   function automatic logic [3:0] port_mask(input logic [1:0] cnt);
      logic [3:0] m;
      m = 4'hf;
      case (cnt)
         `HSC_CNT_FOUR:  m = 4'hf;
         `HSC_CNT_THREE: m = 4'h7;
         `HSC_CNT_TWO:   m = 4'h3;
         default:        m = 4'hf;
      endcase
      return m;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == `HSC_REG_CTRL) || (a == `HSC_REG_LED) || (a == `HSC_REG_STATUS);
   endfunction

   // ---------------------------------------------------------------------
   // pin capture and derived terms
   // ---------------------------------------------------------------------
   always_comb begin
      pins_now.ext_n    = ext_reset_n;
      pins_now.pg       = core_power_good;
      pins_now.gang     = gang_strap_suspend_pin_in;
      pins_now.amber    = switch_polarity_strap_led;
      pins_now.self_pwr = self_power_strap;
      pins_now.oc_n     = port_overcurrent_n;
      pins_now.cnt      = port_count_strap;
      pins_now.nrem     = non_removable_strap;
   end

   // either source low holds the device in reset
   assign rst_src  = !s.sync2.ext_n || !s.sync2.pg;
   assign mask     = port_mask(s.port_cnt);
   // gang mode: first overcurrent flag stands for every active port
   assign oc_eff   = (s.gang ? {4{~s.sync2.oc_n[0]}} : ~s.sync2.oc_n)
                     & mask & {4{s.hub_rst_n}};
   // gang mode: only the first enable switches, the others stay inactive
   assign on_req   = s.pwr_req & mask & {4{s.hub_rst_n}}
                     & (s.gang ? 4'h1 : 4'hf);
   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.sync1 = pins_now;
      next_s.sync2 = s.sync1;

      case (s.seq)
         SEQ_HOLD: begin
            next_s.count = '0;
            next_s.seq   = SEQ_DELAY;
         end
         SEQ_DELAY: begin
            if (s.count == DELAY_LAST) begin
               next_s.count     = '0;
               next_s.hub_rst_n = 1'b1;
               next_s.seq       = SEQ_SAMPLE;
            end else begin
               next_s.count = s.count + 23'h1;
            end
         end
         SEQ_SAMPLE: begin
            // one cycle after release, far inside the strap window
            next_s.gang     = s.sync2.gang;
            next_s.pol_high = s.sync2.amber;
            next_s.self_pwr = s.sync2.self_pwr;
            next_s.port_cnt = s.sync2.cnt;
            next_s.nrem     = s.sync2.nrem;
            next_s.pwr_oe   = 1'b1;
            next_s.seq      = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (s.count == TURN_LAST) begin
               next_s.count   = '0;
               next_s.pin_out = 1'b1;
               next_s.seq     = SEQ_RUN;
            end else begin
               next_s.count = s.count + 23'h1;
            end
         end
         SEQ_RUN: begin
            // gang, polarity and self-power straps stay until the next reset; count and non-removable can be rewritten over CTRL
            next_s.count = '0;
         end
         default: begin
            next_s.seq = SEQ_HOLD;
         end
      endcase

      // register writes take effect at the access edge
      if (wr && s.hub_rst_n) begin
         case (paddr)
            `HSC_REG_CTRL: begin
               next_s.pwr_req  = pwdata[`HSC_CTRL_PWR_LSB +: 4];
               next_s.port_cnt = pwdata[`HSC_CTRL_CNT_LSB +: 2];
               next_s.nrem     = pwdata[`HSC_CTRL_NREM_LSB +: 4];
            end
            `HSC_REG_LED: begin
               next_s.led_sel = pwdata[7:0];
            end
            default: begin
               next_s.led_sel = s.led_sel;
            end
         endcase
      end

      if (rst_src) begin
         // sequencer, straps and register fields back to their initial state; synchronisers and read data kept
         next_s.seq       = SEQ_HOLD;
         next_s.count     = '0;
         next_s.hub_rst_n = 1'b0;
         next_s.gang      = 1'b0;
         next_s.pol_high  = 1'b0;
         next_s.self_pwr  = 1'b0;
         next_s.pwr_req   = '0;
         next_s.port_cnt  = `HSC_CNT_FOUR;
         next_s.nrem      = '0;
         next_s.led_sel   = `HSC_LED_SEL_RESET;
         next_s.pwr_oe    = 1'b0;
         next_s.pin_out   = 1'b0;
      end

      // pins float until polarity is known; the board pull keeps the
      // switch off meanwhile, so a high-active switch never glitches on
      next_s.pwr_lvl   = next_s.pol_high ? on_req : ~on_req;
      next_s.susp_flag = global_suspend && s.pin_out && !rst_src;

      if (rd_setup) begin
         case (paddr)
            `HSC_REG_CTRL: begin
               next_s.prdata = {22'h0, s.nrem, s.port_cnt, s.pwr_req};
            end
            `HSC_REG_LED: begin
               next_s.prdata = {24'h0, s.led_sel};
            end
            `HSC_REG_STATUS: begin
               next_s.prdata = {22'h0, s.susp_flag, oc_eff, s.pin_out, s.self_pwr,
                                s.pol_high, s.gang, s.hub_rst_n};
            end
            default: begin
               next_s.prdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------------
   // indicator driver
   // ---------------------------------------------------------------------
   assign led_link.suspend     = global_suspend && s.hub_rst_n;
   assign led_link.port_on     = port_enabled & on_req & ~oc_eff;
   assign led_link.overcurrent = oc_eff;
   assign led_link.sel         = s.led_sel;

   port_led_drv u_led (
      .pclk    (pclk),
      .presetn (presetn),
      .led     (led_link)
   );

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   assign prdata                     = s.prdata;
   assign pready                     = 1'b1;
   assign pslverr                    = psel && penable && !mapped(paddr);
   assign gang_strap_suspend_pin_out = s.susp_flag;
   assign gang_strap_suspend_pin_oe  = s.pin_out;
   assign port_power_switch_on       = s.pwr_lvl;
   assign port_power_switch_on_oe    = {4{s.pwr_oe}};
   assign led_green                  = led_link.green;
   assign led_amber_out              = led_link.amber;
   // amber two is released while its strap level is being read
   assign led_amber_oe               = {2{s.pwr_oe}};
   assign hub_reset_n                = s.hub_rst_n;
   assign gang_mode                  = s.gang;
   assign self_powered               = s.self_pwr;
   assign active_ports               = mask & {4{s.hub_rst_n}};
   assign non_removable              = s.nrem & mask;
   assign port_overcurrent           = oc_eff;

endmodule
`default_nettype wire

// *** bench/strap_asserts.sv ***
// Purpose: port checks for the reset sequencer and strap block
// Assumes: one pclk domain, presetn async active low
// Notes:   counters measure the long waits instead of long repetitions
`timescale 1ns/1ps
`default_nettype none
module strap_asserts #(
   parameter int unsigned PIN_TURN_CYCLES = 20
)(
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // reset sources
   input wire logic       ext_reset_n,
   input wire logic       core_power_good,
   input wire logic       hub_reset_n,
   // straps and shared pin
   input wire logic       gang_strap_suspend_pin_in,
   input wire logic       gang_strap_suspend_pin_out,
   input wire logic       gang_strap_suspend_pin_oe,
   input wire logic       self_power_strap,
   input wire logic       switch_polarity_strap_led,
   input wire logic       gang_mode,
   input wire logic       self_powered,
   // ports and indicators
   input wire logic       global_suspend,
   input wire logic [3:0] port_power_switch_on,
   input wire logic [3:0] port_overcurrent_n,
   input wire logic [3:0] port_overcurrent,
   input wire logic [3:0] active_ports,
   input wire logic [3:0] led_green,
   input wire logic [1:0] led_amber_out
);
   logic [12:0] good_cnt;
   logic [31:0] up_cnt;
   logic        pol_seen;
   logic        oc0_n;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   assign oc0_n = port_overcurrent_n[0];

   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   // the polarity pin is only a strap while the hub is held in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt <= 13'h0000;
         up_cnt   <= 32'h0;
         pol_seen <= 1'b0;
      end else begin
         good_cnt <= (ext_reset_n && core_power_good && !hub_reset_n) ? good_cnt + 13'h1 : 13'h0;
         up_cnt   <= hub_reset_n ? up_cnt + 32'h1 : 32'h0;
         pol_seen <= hub_reset_n ? pol_seen : switch_polarity_strap_led;
      end
   end

   reset_source_a: assert property (
      !(ext_reset_n && core_power_good) |-> ##[1:4] !hub_reset_n) else $error("hub reset missed");
   release_delay_a: assert property (
      $rose(hub_reset_n) |-> good_cnt >= 13'h0f9c && good_cnt <= 13'h0fa8)
      else $error("hub reset released at wrong time");
   strap_latch_a: assert property (
      $rose(hub_reset_n) |-> ##3 (gang_mode == gang_strap_suspend_pin_in
      && self_powered == self_power_strap)) else $error("strap not latched");
   strap_hold_a: assert property (
      hub_reset_n && $past(hub_reset_n, 4) |-> $stable(gang_mode) && $stable(self_powered))
      else $error("strap value changed");
   pin_input_a: assert property (
      up_cnt < PIN_TURN_CYCLES |-> !gang_strap_suspend_pin_oe) else $error("pin turned early");
   pin_turn_a: assert property (
      $rose(gang_strap_suspend_pin_oe) |-> up_cnt <= PIN_TURN_CYCLES + 4)
      else $error("pin turned late");
   suspend_flag_a: assert property (
      gang_strap_suspend_pin_oe && $past(gang_strap_suspend_pin_oe)
      |-> gang_strap_suspend_pin_out == $past(global_suspend)) else $error("suspend flag wrong");
   leds_off_a: assert property (
      global_suspend && hub_reset_n |=> led_green == 4'h0 && led_amber_out == 2'h0)
      else $error("indicator lit in suspend");
   gang_power_a: assert property (
      gang_mode && $past(gang_mode, 3) |-> port_power_switch_on[3:1] == {3{!pol_seen}})
      else $error("gang mode drives extra enable");
   gang_oc_a: assert property (
      gang_mode && $past(gang_mode, 3)
      |-> port_overcurrent == ({4{!$past(oc0_n, 2)}} & active_ports))
      else $error("gang overcurrent wrong");

   cover property ($rose(hub_reset_n));
   cover property ($rose(gang_strap_suspend_pin_oe));
   cover property (gang_strap_suspend_pin_oe && global_suspend);
   cover property (gang_mode && !oc0_n);
endmodule

bind hub_strap_reset_config strap_asserts #(.PIN_TURN_CYCLES(PIN_TURN_CYCLES)) chk_u (.*);
`default_nettype wire

// *** bench/board_straps.sv ***
// Purpose: board side of the straps, shared pin and power switches
// Assumes: pull resistors win whenever the hub does not drive
// Notes:   no hold of the last driven value, the pull takes over
`timescale 1ns/1ps
`default_nettype none
module board_straps (
   // fitted pulls
   input  wire logic       gang_pull_high,
   input  wire logic       pol_pull_high,
   // hub drivers
   input  wire logic       pin_out,
   input  wire logic       pin_oe,
   input  wire logic       switch_polarity_strap_led_out,
   input  wire logic       switch_polarity_strap_led_oe,
   input  wire logic [3:0] pwr_on,
   input  wire logic [3:0] pwr_oe,
   // resolved wires
   output logic            gang_pin,
   output logic            switch_polarity_strap_led_pin,
   output logic [3:0]      pwr_pin
);
   assign gang_pin   = pin_oe ? pin_out : gang_pull_high;
   assign switch_polarity_strap_led_pin = switch_polarity_strap_led_oe ? switch_polarity_strap_led_out : pol_pull_high;
   // high-active switches need pull-downs, low-active ones pull-ups
   assign pwr_pin    = (pwr_on & pwr_oe) | ({4{!pol_pull_high}} & ~pwr_oe);
endmodule
`default_nettype wire

// *** bench/hub_strap_reset_config_tb.sv ***
// Purpose: self-checking bench for the reset sequencer and strap block
// Assumes: pin turn count shortened, reset delay kept at its full length
// Notes:   apb tasks are entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hub_strap_reset_config_tb;
   localparam int unsigned TURN = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        ext_reset_n, core_power_good, self_power_strap, global_suspend;
   logic        gang_strap_suspend_pin_in, gang_strap_suspend_pin_out, gang_strap_suspend_pin_oe;
   logic        switch_polarity_strap_led, hub_reset_n, gang_mode, self_powered;
   logic        gang_pull, pol_pull;
   logic [1:0]  port_count_strap, led_amber_out, led_amber_oe;
   logic [3:0]  non_removable_strap, port_power_switch_on, port_power_switch_on_oe;
   logic [3:0]  port_overcurrent_n, led_green, port_enabled, active_ports;
   logic [3:0]  non_removable, port_overcurrent, pwr_pin;
   int          n_errors, checked;

   hub_strap_reset_config #(.PIN_TURN_CYCLES(TURN)) dut_u (.*);

   board_straps board_u (.gang_pull_high(gang_pull), .pol_pull_high(pol_pull),
      .pin_out(gang_strap_suspend_pin_out), .pin_oe(gang_strap_suspend_pin_oe),
      .switch_polarity_strap_led_out(led_amber_out[1]), .switch_polarity_strap_led_oe(led_amber_oe[1]),
      .pwr_on(port_power_switch_on), .pwr_oe(port_power_switch_on_oe),
      .gang_pin(gang_strap_suspend_pin_in), .switch_polarity_strap_led_pin(switch_polarity_strap_led),
      .pwr_pin(pwr_pin));

   always #5 pclk = ~pclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a slave that never answers counts as a failure
      if (pready !== 1'b1) n_errors++;
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // one reset source held low, then the full sequence with fresh straps
   task automatic boot(input logic ext, g, p, s, input logic [1:0] cnt, input logic [3:0] nr);
      int n;
      logic [3:0] m;
      gang_pull           <= g;
      pol_pull            <= p;
      self_power_strap    <= s;
      port_count_strap    <= cnt;
      non_removable_strap <= nr;
      if (ext) ext_reset_n <= 1'b0;
      else core_power_good <= 1'b0;
      repeat (8) @(posedge pclk);
      check(32'(hub_reset_n), 32'h0);
      check(32'(gang_mode), 32'h0);
      check(32'(gang_strap_suspend_pin_oe), 32'h0);
      ext_reset_n     <= 1'b1;
      core_power_good <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (hub_reset_n !== 1'b1 && n < 5000);
      check(32'(n >= 32'h0f9e && n <= 32'h0fa8), 32'h1);
      repeat (4) @(posedge pclk);
      check(32'(gang_mode), 32'(g));
      check(32'(self_powered), 32'(s));
      // port count code: 0 four, 1 three, 2 two, 3 four
      m = (cnt == 2'h2) ? 4'h3 : ((cnt == 2'h1) ? 4'h7 : 4'hf);
      check(32'(active_ports), 32'(m));
      // non-removable marks only count for ports that are active
      check(32'(non_removable), 32'(nr & m));
      check(32'(pwr_pin), p ? 32'h0 : 32'hf);
      check(32'(gang_strap_suspend_pin_oe), 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check(32'(rdata[2]), 32'(p));
      repeat (TURN) @(posedge pclk);
      check(32'(gang_strap_suspend_pin_oe), 32'h1);
   endtask

   // firmware overrides count and non-removable, requests ports 2 and 3
   task automatic power_ind;
      apb(1'b1, 8'h00, 32'h0000_00c6);
      repeat (3) @(posedge pclk);
      check(32'(pwr_pin), 32'h9);
      check(32'(non_removable), 32'h3);
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, rerr}, 32'h1);
      check(rdata, 32'h0);
   endtask

   task automatic leds;
      port_enabled <= 4'h3;
      repeat (3) @(posedge pclk);
      check(32'(led_green), 32'h2);
      apb(1'b1, 8'h04, 32'h0000_002d);
      repeat (2) @(posedge pclk);
      check(32'(led_green), 32'h4);
      check(32'(led_amber_out), 32'h1);
      global_suspend   <= 1'b1;
      self_power_strap <= 1'b1;
      repeat (3) @(posedge pclk);
      check(32'(led_green), 32'h0);
      check(32'(led_amber_out), 32'h0);
      check(32'(gang_strap_suspend_pin_in), 32'h1);
      check(32'(self_powered), 32'h0);
      global_suspend <= 1'b0;
      repeat (3) @(posedge pclk);
      check(32'(gang_strap_suspend_pin_in), 32'h0);
      check(32'(led_green), 32'h4);
   endtask

   // gang mode, high-active switches, overcurrent only from the first input
   task automatic power_gang;
      apb(1'b1, 8'h00, 32'h0000_002f);
      repeat (3) @(posedge pclk);
      check(32'(pwr_pin), 32'h1);
      port_overcurrent_n <= 4'he;
      repeat (3) @(posedge pclk);
      check(32'(port_overcurrent), 32'h3);
      // indicator register lags the overcurrent flag by one edge
      @(posedge pclk);
      check(32'(led_amber_out), 32'h3);
      port_overcurrent_n <= 4'h1;
      repeat (3) @(posedge pclk);
      check(32'(port_overcurrent), 32'h0);
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ext_reset_n, core_power_good, self_power_strap, global_suspend} = 4'h4;
      {gang_pull, pol_pull, port_count_strap, non_removable_strap} = '0;
      port_overcurrent_n = 4'hf;
      port_enabled       = 4'h0;
      n_errors           = 0;
      checked            = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      boot(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 4'h5);
      power_ind();
      leds();
      boot(1'b0, 1'b1, 1'b1, 1'b1, 2'h2, 4'ha);
      power_gang();
      end_of_test();
   end
endmodule
`default_nettype wire
